/* File: rtl/htrr_regs.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
// What this block does
// - writing one to the humidity stop bit ends a continuous humidity run.
// - writing one to the temperature stop bit ends a continuous temperature run.
// - a zero in either stop bit leaves that sensor alone.
// - activity bit 1 reads one while humidity is measuring.
// - activity bit 0 reads one while temperature is measuring; both reset to zero.
// - temperature result bits 23:17 hold a crc-7 over valid flag and data.
// - temperature result bit 16 is one only when the data are valid.
// - temperature result bits 15:0 hold the latest reading, little endian, 1/64 K.
// - humidity result bits 23:17 hold a crc-7 over valid flag and data.
// - humidity result bit 16 is one only when the data are valid.
// - humidity result bits 15:0 hold the latest reading, little endian, 1/512 %RH.
// - reading the first byte of a result latches all three bytes into a shadow.
// - a one in a start bit begins a measurement; a zero does nothing.
// - run bits pick single shot at zero and continuous at one, resetting to zero.
module htrr_regs
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [15:0] temp_sample,
    input  wire logic        temp_ok,
    input  wire logic [15:0] hum_sample,
    input  wire logic        hum_ok,
    output logic [7:0]       rdata_q,
    output logic             irq_q
);
    logic [1:0]  run_q;
    logic [1:0]  irq_stat_q;
    logic [1:0]  irq_en_q;
    logic [23:0] t_shadow_q;
    logic [23:0] h_shadow_q;
    logic [1:0]  busy;
    logic [1:0]  done;
    logic [23:0] t_res;
    logic [23:0] h_res;
    logic [7:0]  rdata_d;

    wire wr_run   = wr && (addr == htrr_pkg::HTRR_ADDR_RUN);
    wire wr_start = wr && (addr == htrr_pkg::HTRR_ADDR_START);
    wire wr_halt  = wr && (addr == htrr_pkg::HTRR_ADDR_HALT);
    wire wr_clr   = wr && (addr == htrr_pkg::HTRR_ADDR_IRQ_CLR);
    wire wr_en    = wr && (addr == htrr_pkg::HTRR_ADDR_IRQ_EN);
    wire [1:0] start_v = wr_start ? wdata[1:0] : 2'b00;
    wire [1:0] halt_v  = wr_halt ? wdata[1:0] : 2'b00;
    // a read or write of the first byte latches the result into its shadow
    wire t_latch = (rd || wr) && (addr == htrr_pkg::HTRR_ADDR_TEMP);
    wire h_latch = (rd || wr) && (addr == htrr_pkg::HTRR_ADDR_HUM);
    wire [1:0] irq_stat_d = done | (irq_stat_q & ~(wr_clr ? wdata[1:0] : 2'b00));   // set beats clear

    htrr_sensor_chan u_temp
    (
        .clk        (clk),
        .reset      (reset),
        .start      (start_v[htrr_pkg::HTRR_BIT_T]),
        .halt       (halt_v[htrr_pkg::HTRR_BIT_T]),
        .continuous (run_q[htrr_pkg::HTRR_BIT_T]),
        .sample     (temp_sample),
        .sample_ok  (temp_ok),
        .busy_q     (busy[htrr_pkg::HTRR_BIT_T]),
        .done_q     (done[htrr_pkg::HTRR_BIT_T]),
        .result_q   (t_res)
    );

    htrr_sensor_chan u_hum
    (
        .clk        (clk),
        .reset      (reset),
        .start      (start_v[htrr_pkg::HTRR_BIT_H]),
        .halt       (halt_v[htrr_pkg::HTRR_BIT_H]),
        .continuous (run_q[htrr_pkg::HTRR_BIT_H]),
        .sample     (hum_sample),
        .sample_ok  (hum_ok),
        .busy_q     (busy[htrr_pkg::HTRR_BIT_H]),
        .done_q     (done[htrr_pkg::HTRR_BIT_H]),
        .result_q   (h_res)
    );

    // byte lanes of a result: little endian, shadow for bytes 1 and 2
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (addr)
            htrr_pkg::HTRR_ADDR_RUN:          rdata_d = {6'b00_0000, run_q};
            htrr_pkg::HTRR_ADDR_ACTIVITY:     rdata_d = {6'b00_0000, busy};
            htrr_pkg::HTRR_ADDR_TEMP:         rdata_d = t_res[7:0];
            htrr_pkg::HTRR_ADDR_TEMP + 8'h01: rdata_d = t_shadow_q[15:8];
            htrr_pkg::HTRR_ADDR_TEMP + 8'h02: rdata_d = t_shadow_q[23:16];
            htrr_pkg::HTRR_ADDR_HUM:          rdata_d = h_res[7:0];
            htrr_pkg::HTRR_ADDR_HUM + 8'h01:  rdata_d = h_shadow_q[15:8];
            htrr_pkg::HTRR_ADDR_HUM + 8'h02:  rdata_d = h_shadow_q[23:16];
            htrr_pkg::HTRR_ADDR_IRQ_STAT:     rdata_d = {6'b00_0000, irq_stat_q};
            htrr_pkg::HTRR_ADDR_IRQ_EN:       rdata_d = {6'b00_0000, irq_en_q};
            default:                          rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            run_q      <= 2'b00;
            irq_stat_q <= 2'b00;
            irq_en_q   <= 2'b00;
            irq_q      <= 1'b0;
            rdata_q    <= htrr_pkg::HTRR_RESET_BYTE;
            t_shadow_q <= 24'h00_0000;
            h_shadow_q <= 24'h00_0000;
        end
        else
        begin
            if (wr_run)
                run_q <= wdata[1:0];
            if (wr_en)
                irq_en_q <= wdata[1:0];
            irq_stat_q <= irq_stat_d;
            irq_q      <= |(irq_stat_d & (wr_en ? wdata[1:0] : irq_en_q));
            rdata_q    <= rd ? rdata_d : 8'h00;
            if (t_latch)
                t_shadow_q <= t_res;
            if (h_latch)
                h_shadow_q <= h_res;
        end
    end

    // assertions
    property p_halt_hum;
        @(posedge clk) disable iff (reset)
        (wr_halt && wdata[1] && run_q[1]) |=> !busy[1];
    endproperty
    a_halt_hum: assert property (p_halt_hum) else $error("humidity run not halted");

    property p_halt_temp;
        @(posedge clk) disable iff (reset)
        (wr_halt && wdata[0] && run_q[0]) |=> !busy[0];
    endproperty
    a_halt_temp: assert property (p_halt_temp) else $error("temperature run not halted");

    property p_halt_zero;
        @(posedge clk) disable iff (reset)
        (wr_halt && !wdata[0] && busy[0] && !done[0]) |=> busy[0] || done[0];
    endproperty
    a_halt_zero: assert property (p_halt_zero) else $error("zero stop bit disturbed sensor");

    sequence s_start_hum;
        wr_start && wdata[1] && !busy[1];
    endsequence
    property p_start_hum;
        @(posedge clk) disable iff (reset) s_start_hum |=> busy[1];
    endproperty
    a_start_hum: assert property (p_start_hum) else $error("humidity start not taken");

    property p_stat_read;
        @(posedge clk) disable iff (reset)
        (rd && addr == htrr_pkg::HTRR_ADDR_ACTIVITY) |=> rdata_q == {6'b00_0000, $past(busy)};
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("activity read mismatch");

    property p_reset_stat;
        @(posedge clk) $past(reset) |-> busy == 2'b00 && run_q == 2'b00;
    endproperty
    a_reset_stat: assert property (p_reset_stat) else $error("status not cleared by reset");

    property p_shadow;
        @(posedge clk) disable iff (reset) t_latch |=> t_shadow_q == $past(t_res);
    endproperty
    a_shadow: assert property (p_shadow) else $error("temperature shadow not latched");

    property p_single_end;
        @(posedge clk) disable iff (reset)
        (done[0] && !$past(run_q[0]) && !$past(start_v[0])) |-> !busy[0];
    endproperty
    a_single_end: assert property (p_single_end) else $error("single shot did not end");

    property p_valid;
        @(posedge clk) disable iff (reset)
        done[1] |-> h_res[htrr_pkg::HTRR_VALID_BIT] == $past(hum_ok) && h_res[15:0] == $past(hum_sample);
    endproperty
    a_valid: assert property (p_valid) else $error("humidity result not captured");

    sequence s_start_temp;
        wr_start && wdata[0] && !busy[0];
    endsequence
    property p_start_temp;
        @(posedge clk) disable iff (reset) s_start_temp |=> busy[0];
    endproperty
    a_start_temp: assert property (p_start_temp) else $error("temperature start not taken");

    property p_start_zero_temp;
        @(posedge clk) disable iff (reset)
        (wr_start && !wdata[0] && !busy[0]) |=> !busy[0];
    endproperty
    a_start_zero_temp: assert property (p_start_zero_temp) else $error("zero start bit began temperature");

    property p_start_zero_hum;
        @(posedge clk) disable iff (reset)
        (wr_start && !wdata[1] && !busy[1]) |=> !busy[1];
    endproperty
    a_start_zero_hum: assert property (p_start_zero_hum) else $error("zero start bit began humidity");

    // a stop aimed at a single shot must not cut it short
    property p_halt_single_temp;
        @(posedge clk) disable iff (reset)
        (wr_halt && wdata[0] && !run_q[0] && busy[0]) |=> busy[0] || done[0];
    endproperty
    a_halt_single_temp: assert property (p_halt_single_temp) else $error("single shot cut by stop");

    property p_halt_zero_hum;
        @(posedge clk) disable iff (reset)
        (wr_halt && !wdata[1] && busy[1] && !done[1]) |=> busy[1] || done[1];
    endproperty
    a_halt_zero_hum: assert property (p_halt_zero_hum) else $error("zero stop bit disturbed humidity");

    property p_cont_hold_hum;
        @(posedge clk) disable iff (reset)
        (busy[1] && run_q[1] && !halt_v[1]) |=> busy[1];
    endproperty
    a_cont_hold_hum: assert property (p_cont_hold_hum) else $error("continuous humidity run dropped");

    property p_single_end_hum;
        @(posedge clk) disable iff (reset)
        (done[1] && !$past(run_q[1]) && !$past(start_v[1])) |-> !busy[1];
    endproperty
    a_single_end_hum: assert property (p_single_end_hum) else $error("humidity single shot did not end");

    // result and done load on the same edge, so a quiet done means a frozen result
    property p_result_hold_temp;
        @(posedge clk) disable iff (reset)
        !done[0] |-> $stable(t_res);
    endproperty
    a_result_hold_temp: assert property (p_result_hold_temp) else $error("temperature result moved early");

    property p_result_hold_hum;
        @(posedge clk) disable iff (reset)
        !done[1] |-> $stable(h_res);
    endproperty
    a_result_hold_hum: assert property (p_result_hold_hum) else $error("humidity result moved early");

    property p_valid_temp;
        @(posedge clk) disable iff (reset)
        done[0] |-> t_res[htrr_pkg::HTRR_VALID_BIT] == $past(temp_ok);
    endproperty
    a_valid_temp: assert property (p_valid_temp) else $error("temperature valid flag not captured");

    property p_data_temp;
        @(posedge clk) disable iff (reset)
        done[0] |-> t_res[15:0] == $past(temp_sample);
    endproperty
    a_data_temp: assert property (p_data_temp) else $error("temperature data not captured");

    property p_data_hum;
        @(posedge clk) disable iff (reset)
        done[1] |-> h_res[15:0] == $past(hum_sample);
    endproperty
    a_data_hum: assert property (p_data_hum) else $error("humidity data not captured");

    property p_shadow_hum;
        @(posedge clk) disable iff (reset) h_latch |=> h_shadow_q == $past(h_res);
    endproperty
    a_shadow_hum: assert property (p_shadow_hum) else $error("humidity shadow not latched");

    property p_shadow_hold_temp;
        @(posedge clk) disable iff (reset) !t_latch |=> $stable(t_shadow_q);
    endproperty
    a_shadow_hold_temp: assert property (p_shadow_hold_temp) else $error("temperature shadow moved");

    sequence s_rd_temp0;
        rd && (addr == htrr_pkg::HTRR_ADDR_TEMP);
    endsequence
    property p_lane0_temp;
        @(posedge clk) disable iff (reset) s_rd_temp0 |=> rdata_q == $past(t_res[7:0]);
    endproperty
    a_lane0_temp: assert property (p_lane0_temp) else $error("temperature byte0 not live");

    sequence s_rd_temp1;
        rd && (addr == htrr_pkg::HTRR_ADDR_TEMP + 8'h01);
    endsequence
    property p_lane1_temp;
        @(posedge clk) disable iff (reset) s_rd_temp1 |=> rdata_q == $past(t_shadow_q[15:8]);
    endproperty
    a_lane1_temp: assert property (p_lane1_temp) else $error("temperature byte1 not from shadow");

    sequence s_rd_temp2;
        rd && (addr == htrr_pkg::HTRR_ADDR_TEMP + 8'h02);
    endsequence
    property p_lane2_temp;
        @(posedge clk) disable iff (reset) s_rd_temp2 |=> rdata_q == $past(t_shadow_q[23:16]);
    endproperty
    a_lane2_temp: assert property (p_lane2_temp) else $error("temperature byte2 not from shadow");

    property p_lane2_hum;
        @(posedge clk) disable iff (reset)
        (rd && addr == htrr_pkg::HTRR_ADDR_HUM + 8'h02) |=> rdata_q == $past(h_shadow_q[23:16]);
    endproperty
    a_lane2_hum: assert property (p_lane2_hum) else $error("humidity byte2 not from shadow");

    // read data stand one cycle only, so a stale byte cannot be mistaken for a fresh one
    property p_rdata_idle;
        @(posedge clk) disable iff (reset) !rd |=> rdata_q == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outlived its cycle");

    property p_irq_level;
        @(posedge clk) disable iff (reset) irq_q == |(irq_stat_q & irq_en_q);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

    property p_stat_set;
        @(posedge clk) disable iff (reset) done[0] |=> irq_stat_q[0];
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("temperature done not recorded");
endmodule : htrr_regs

/* File: rtl/htrr_pkg.sv */
package htrr_pkg;
    // byte offsets of the register port
    localparam logic [7:0] HTRR_ADDR_RUN      = 8'h21;
    localparam logic [7:0] HTRR_ADDR_START    = 8'h22;
    localparam logic [7:0] HTRR_ADDR_HALT     = 8'h23;
    localparam logic [7:0] HTRR_ADDR_ACTIVITY = 8'h24;
    localparam logic [7:0] HTRR_ADDR_TEMP     = 8'h30;
    localparam logic [7:0] HTRR_ADDR_HUM      = 8'h33;
    localparam logic [7:0] HTRR_ADDR_IRQ_STAT = 8'h40;
    localparam logic [7:0] HTRR_ADDR_IRQ_CLR  = 8'h41;
    localparam logic [7:0] HTRR_ADDR_IRQ_EN   = 8'h42;
    // bit positions in stop/start/run/status bytes
    localparam int HTRR_BIT_T = 0;
    localparam int HTRR_BIT_H = 1;
    // result field layout
    localparam int HTRR_VALID_BIT = 16;
    localparam int HTRR_CRC_LSB   = 17;
    localparam logic [7:0] HTRR_RESET_BYTE = 8'h00;
    // crc-7 polynomial (x^7+x^3+1) and seed
    localparam logic [6:0] HTRR_CRC_POLY = 7'h09;
    localparam logic [6:0] HTRR_CRC_INIT = 7'h7f;
    // conversion time of one measurement
    localparam int HTRR_CONV_US     = 100;
    localparam int HTRR_CLK_MHZ     = 40;
    localparam int HTRR_CONV_CYCLES = HTRR_CONV_US * HTRR_CLK_MHZ;
endpackage : htrr_pkg

/* File: rtl/htrr_sensor_chan.sv */
`timescale 1ns/1ps
module htrr_sensor_chan
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        start,
    input  wire logic        halt,
    input  wire logic        continuous,
    input  wire logic [15:0] sample,
    input  wire logic        sample_ok,
    output logic             busy_q,
    output logic             done_q,
    output logic [23:0]      result_q
);
    localparam logic [12:0] CONV_LAST = 13'(htrr_pkg::HTRR_CONV_CYCLES - 1);

    logic [12:0] cnt_q;
    wire         finish = busy_q && (cnt_q == CONV_LAST);

    function automatic logic [6:0] crc7(input logic [16:0] din);
        logic [6:0] c;
        logic       fb;
        c = htrr_pkg::HTRR_CRC_INIT;
        for (int i = 16; i >= 0; i--)
        begin
            fb = c[6] ^ din[i];
            c  = {c[5:0], 1'b0} ^ (fb ? htrr_pkg::HTRR_CRC_POLY : 7'h00);
        end
        return c;
    endfunction : crc7

    wire [16:0] payload = {sample_ok, sample};

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            busy_q   <= 1'b0;
            cnt_q    <= '0;
            done_q   <= 1'b0;
            result_q <= 24'h00_0000;
        end
        else
        begin
            done_q <= finish;
            if (halt && continuous)
                busy_q <= 1'b0;
            else if (start && !busy_q)
                busy_q <= 1'b1;
            else if (finish && !continuous)
                busy_q <= 1'b0;
            cnt_q <= (!busy_q || finish) ? 13'h0000 : cnt_q + 13'h0001;
            if (finish)
                result_q <= {crc7(payload), payload};
        end
    end
endmodule : htrr_sensor_chan

/* File: verification/htrr_host_model.sv */
`timescale 1ns/1ps
module htrr_host_model
(
    input  wire logic       clk,
    output logic [7:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr,
    output logic            rd,
    input  wire logic [7:0] rdata_q
);
    initial
    begin
        addr  = 8'h00;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= (a == htrr_pkg::HTRR_ADDR_HALT) ? {6'h00, d[1:0]} : d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // a released data bus must not look like it still holds the value
        wdata <= ~wdata;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        // data stand in the cycle after the strobe; take them at its closing edge
        @(posedge clk);
        d = rdata_q;
    endtask : rd_reg
endmodule : htrr_host_model

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        clk;
    logic        reset;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [15:0] temp_sample;
    logic        temp_ok;
    logic [15:0] hum_sample;
    logic        hum_ok;
    logic [7:0]  rdata_q;
    logic        irq_q;
    int          mismatches;
    int          n_tests;

    htrr_regs i_dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .temp_sample(temp_sample), .temp_ok(temp_ok), .hum_sample(hum_sample), .hum_ok(hum_ok),
        .rdata_q(rdata_q), .irq_q(irq_q));
    htrr_host_model i_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q));

    always #12.5 clk = ~clk;

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // crc over {valid, data}, msb first
    function automatic logic [23:0] exp_word(input logic valid, input logic [15:0] data);
        logic [16:0] msg;
        logic [6:0]  crc;
        msg = {valid, data};
        crc = htrr_pkg::HTRR_CRC_INIT;
        for (int i = 16; i >= 0; i--)
            crc = {crc[5:0], 1'b0} ^ ((crc[6] ^ msg[i]) ? htrr_pkg::HTRR_CRC_POLY : 7'h00);
        return {crc, msg};
    endfunction : exp_word

    task automatic rd8(input logic [7:0] a, input string name, input logic [7:0] exp);
        logic [7:0] b;
        i_host.rd_reg(a, b);
        check(name, {16'h0000, b}, {16'h0000, exp});
    endtask : rd8

    // byte0 first, so the shadow is loaded before bytes 1 and 2
    task automatic rd24(input logic [7:0] a, output logic [23:0] w);
        for (int k = 0; k < 3; k++)
            i_host.rd_reg(a + 8'(k), w[8*k +: 8]);
    endtask : rd24

    task automatic test_reset;
        logic [23:0] w;
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "activity", 8'h00);
        rd8(htrr_pkg::HTRR_ADDR_RUN, "run", 8'h00);
        rd8(8'h50, "unmapped", 8'h00);
        rd24(htrr_pkg::HTRR_ADDR_TEMP, w);
        check("temp at reset", w, 24'h00_0000);
        check("irq at reset", {23'h00_0000, irq_q}, 24'h00_0000);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_single_temp;
        logic [23:0] w;
        temp_sample <= 16'h1234;
        temp_ok     <= 1'b1;
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_START, 8'h00);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "zero start", 8'h00);
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_START, 8'h01);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "temp busy", 8'h01);
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_HALT, 8'h01);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "single halt ignored", 8'h01);
        repeat (htrr_pkg::HTRR_CONV_CYCLES + 8) @(posedge clk);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "temp idle", 8'h00);
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_IRQ_EN, 8'h01);
        @(posedge clk);
        check("irq raised", {23'h00_0000, irq_q}, 24'h00_0001);
        rd24(htrr_pkg::HTRR_ADDR_TEMP, w);
        check("temp result", w, exp_word(1'b1, 16'h1234));
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_IRQ_CLR, 8'h01);
        repeat (2) @(posedge clk);
        check("irq cleared", {23'h00_0000, irq_q}, 24'h00_0000);
        $display("test_single_temp done");
    endtask : test_single_temp

    task automatic test_continuous;
        logic [23:0] w;
        logic [23:0] e;
        hum_sample <= 16'habcd;
        hum_ok     <= 1'b0;
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_RUN, 8'h03);
        rd8(htrr_pkg::HTRR_ADDR_RUN, "run readback", 8'h03);
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_START, 8'h03);
        repeat (htrr_pkg::HTRR_CONV_CYCLES + 8) @(posedge clk);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "both running", 8'h03);
        rd8(htrr_pkg::HTRR_ADDR_IRQ_STAT, "irq status", 8'h03);
        rd8(htrr_pkg::HTRR_ADDR_IRQ_EN, "irq enable", 8'h01);
        rd24(htrr_pkg::HTRR_ADDR_HUM, w);
        check("hum result", w, exp_word(1'b0, 16'habcd));
        // latch the old word, let a new one land, then the upper bytes must still be old
        hum_sample <= 16'h5678;
        hum_ok     <= 1'b1;
        e = exp_word(1'b0, 16'habcd);
        rd8(htrr_pkg::HTRR_ADDR_HUM, "hum byte0 latch", e[7:0]);
        repeat (htrr_pkg::HTRR_CONV_CYCLES + 8) @(posedge clk);
        rd8(htrr_pkg::HTRR_ADDR_HUM + 8'h01, "hum shadow byte1", e[15:8]);
        rd8(htrr_pkg::HTRR_ADDR_HUM + 8'h02, "hum shadow byte2", e[23:16]);
        rd24(htrr_pkg::HTRR_ADDR_HUM, w);
        check("hum new result", w, exp_word(1'b1, 16'h5678));
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_HALT, 8'h00);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "zero halt", 8'h03);
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_HALT, 8'h01);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "temp halted", 8'h02);
        i_host.wr_reg(htrr_pkg::HTRR_ADDR_HALT, 8'h02);
        rd8(htrr_pkg::HTRR_ADDR_ACTIVITY, "hum halted", 8'h00);
        $display("test_continuous done");
    endtask : test_continuous

    initial
    begin
        clk         = 1'b0;
        reset       = 1'b1;
        temp_sample = 16'h0000;
        temp_ok     = 1'b0;
        hum_sample  = 16'h0000;
        hum_ok      = 1'b0;
        mismatches  = 0;
        n_tests     = 0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        test_reset();
        test_single_temp();
        test_continuous();
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule : tb_top
